// [verilog/cfr_cfg.svh]
// constants for the core flow control register bank
`ifndef CFR_CFG_SVH
`define CFR_CFG_SVH

// ----------------------------------------------------------------
// register module and index selects
// ----------------------------------------------------------------
`define CFR_MOD_PFX 4'hB
`define CFR_MOD_IP 4'hC
`define CFR_MOD_SYS 4'hD
`define CFR_IDX_IP 4'h0
`define CFR_IDX_SP 4'h1
`define CFR_IDX_IV 4'h2
`define CFR_IDX_LC0 4'h6
`define CFR_IDX_LC1 4'h7

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define CFR_PFX_DATA_MSB 7
`define CFR_PFX_SRC_BIT 0
`define CFR_PFX_DST_MSB 2
`define CFR_PFX_DST_LSB 1
`define CFR_SP_MSB 3
`define CFR_STACK_DEPTH 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CFR_PFX_RST 16'h0000
`define CFR_PFX_IDX_RST 3'h0
`define CFR_IP_RST 16'h8000
`define CFR_SP_RST 4'hF
`define CFR_IV_RST 16'h0000
`define CFR_LC_RST 16'h0000
`define CFR_SP_PAD 12'h000

`endif

// [verilog/cfr_pkg.sv]
// types shared by the flow control register bank
package cfr_pkg;
  typedef logic [15:0] cfr_word_t;
  typedef logic [3:0] cfr_sel_t;
  typedef logic [3:0] cfr_sp_t;
  typedef logic [2:0] cfr_pfx_idx_t;
  typedef logic [7:0] cfr_pfx_data_t;
  typedef logic [1:0] cfr_dst_hi_t;
endpackage

// [verilog/cfr_loop_count.sv]
// one loop counter with load and decrement
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_loop_count #(
  parameter cfr_pkg::cfr_word_t RST_VAL = `CFR_LC_RST
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // direct register write
  input wire logic load_en,
  input wire cfr_pkg::cfr_word_t load_data,
  // decrement and branch
  input wire logic dec_en,
  output cfr_pkg::cfr_word_t count,
  output logic taken
);
  import cfr_pkg::*;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  cfr_word_t count_reg;
  cfr_word_t count_next;
  wire cfr_word_t count_dec;

  assign count_dec = count_reg - 16'h0001;
  assign count_next = load_en ? load_data :
                      dec_en ? count_dec : count_reg;
  assign taken = dec_en && (count_dec != 16'h0000);
  assign count = count_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= RST_VAL;
    end else begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_lc_dec;
    @(posedge clk) disable iff (!arst_n)
      (dec_en && !load_en) |=> (count_reg == $past(count_reg) - 16'h0001);
  endproperty
  a_lc_dec: assert property (p_lc_dec)
    else $error("loop counter did not drop by one");

  property p_lc_taken;
    @(posedge clk) disable iff (!arst_n)
      dec_en |-> (taken == (count_reg != 16'h0001));
  endproperty
  a_lc_taken: assert property (p_lc_taken)
    else $error("branch decision does not match counter");
endmodule

// [verilog/cfr_stack.sv]
// sixteen word hardware stack with its top pointer
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_stack (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // push and pop
  input wire logic push_en,
  input wire cfr_pkg::cfr_word_t push_data,
  input wire logic pop_en,
  output cfr_pkg::cfr_word_t pop_data,
  // pointer register access
  input wire logic sp_wr_en,
  input wire cfr_pkg::cfr_sp_t sp_wr_data,
  output cfr_pkg::cfr_sp_t sp
);
  import cfr_pkg::*;

  // ----------------------------------------------------------------
  // storage and pointer
  // ----------------------------------------------------------------
  cfr_word_t mem [`CFR_STACK_DEPTH];
  cfr_sp_t sp_reg;
  cfr_sp_t sp_next;
  cfr_word_t pop_reg;
  wire cfr_sp_t sp_inc;
  wire cfr_sp_t sp_dec;

  assign sp_inc = sp_reg + 4'h1;
  assign sp_dec = sp_reg - 4'h1;
  // write then increment, decrement then read
  assign sp_next = sp_wr_en ? sp_wr_data :
                   push_en ? sp_inc :
                   pop_en ? sp_dec : sp_reg;
  assign sp = sp_reg;
  assign pop_data = pop_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_reg <= `CFR_SP_RST;
      pop_reg <= 16'h0000;
    end else begin
      sp_reg <= sp_next;
      if (pop_en && !push_en) begin
        pop_reg <= mem[sp_dec];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push_en) begin
      mem[sp_reg] <= push_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_sp_push;
    @(posedge clk) disable iff (!arst_n)
      (push_en && !sp_wr_en) |=> (sp_reg == $past(sp_reg) + 4'h1);
  endproperty
  a_sp_push: assert property (p_sp_push)
    else $error("pointer did not rise after push");

  property p_sp_round;
    @(posedge clk) disable iff (!arst_n)
      (push_en && !pop_en && !sp_wr_en) ##1
      (pop_en && !push_en && !sp_wr_en)
      |=> (pop_data == $past(push_data, 2)) && (sp_reg == $past(sp_reg, 2));
  endproperty
  a_sp_round: assert property (p_sp_round)
    else $error("pop did not return the last pushed word");
endmodule

// [verilog/cfr_flow_regs.sv]
// core flow control registers: prefix, fetch address, stack, vector, loops
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_flow_regs (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register write port
  input wire logic wr_en,
  input wire cfr_pkg::cfr_sel_t wr_mod,
  input wire cfr_pkg::cfr_sel_t wr_idx,
  input wire cfr_pkg::cfr_word_t wr_data,
  // register read port
  input wire logic rd_en,
  input wire cfr_pkg::cfr_sel_t rd_mod,
  input wire cfr_pkg::cfr_sel_t rd_idx,
  output cfr_pkg::cfr_word_t rd_data,
  // program fetch
  input wire logic fetch_en,
  output cfr_pkg::cfr_word_t fetch_addr,
  // operand prefix to the decoder
  output cfr_pkg::cfr_pfx_data_t pfx_data,
  output logic pfx_src_hi,
  output cfr_pkg::cfr_dst_hi_t pfx_dst_hi,
  // stack
  input wire logic push_en,
  input wire cfr_pkg::cfr_word_t push_data,
  input wire logic pop_en,
  output cfr_pkg::cfr_word_t pop_data,
  output cfr_pkg::cfr_sp_t stack_top,
  // interrupt acknowledge
  input wire logic int_ack,
  // decrement and jump
  input wire logic decrement_jump_nonzero_en,
  input wire logic decrement_jump_nonzero_sel,
  input wire cfr_pkg::cfr_word_t decrement_jump_nonzero_target,
  output logic decrement_jump_nonzero_taken
);
  import cfr_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  cfr_word_t pfx_reg;
  cfr_word_t pfx_next;
  cfr_pfx_idx_t pfx_idx_reg;
  cfr_pfx_idx_t pfx_idx_next;
  cfr_word_t ip_reg;
  cfr_word_t ip_next;
  cfr_word_t iv_reg;
  cfr_word_t iv_next;
  cfr_word_t rd_data_reg;
  cfr_word_t rd_data_next;
  logic decrement_jump_nonzero_taken_reg;
  logic seen_reg;
  wire cfr_word_t lc0_count;
  wire cfr_word_t lc1_count;
  wire cfr_sp_t stack_top_w;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire logic wr_pfx;
  wire logic wr_ip;
  wire logic wr_sys;
  wire logic wr_sp;
  wire logic wr_iv;
  wire logic wr_lc0;
  wire logic wr_lc1;

  // any prefix index reaches the same register
  assign wr_pfx = wr_en && (wr_mod == `CFR_MOD_PFX);
  assign wr_ip = wr_en && (wr_mod == `CFR_MOD_IP) &&
                 (wr_idx == `CFR_IDX_IP);
  assign wr_sys = wr_en && (wr_mod == `CFR_MOD_SYS);
  assign wr_sp = wr_sys && (wr_idx == `CFR_IDX_SP);
  assign wr_iv = wr_sys && (wr_idx == `CFR_IDX_IV);
  assign wr_lc0 = wr_sys && (wr_idx == `CFR_IDX_LC0);
  assign wr_lc1 = wr_sys && (wr_idx == `CFR_IDX_LC1);

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire logic rd_pfx;
  wire logic rd_ip;
  wire logic rd_sys;
  wire logic rd_sp;
  wire logic rd_iv;
  wire logic rd_lc0;
  wire logic rd_lc1;
  wire cfr_word_t sp_word;
  wire cfr_word_t rd_sel;

  assign rd_pfx = rd_mod == `CFR_MOD_PFX;
  assign rd_ip = (rd_mod == `CFR_MOD_IP) && (rd_idx == `CFR_IDX_IP);
  assign rd_sys = rd_mod == `CFR_MOD_SYS;
  assign rd_sp = rd_sys && (rd_idx == `CFR_IDX_SP);
  assign rd_iv = rd_sys && (rd_idx == `CFR_IDX_IV);
  assign rd_lc0 = rd_sys && (rd_idx == `CFR_IDX_LC0);
  assign rd_lc1 = rd_sys && (rd_idx == `CFR_IDX_LC1);
  // upper pointer bits are reserved and read zero
  assign sp_word = {`CFR_SP_PAD, stack_top_w};
  assign rd_sel = rd_pfx ? pfx_reg :
                  rd_ip ? ip_reg :
                  rd_sp ? sp_word :
                  rd_iv ? iv_reg :
                  rd_lc0 ? lc0_count :
                  rd_lc1 ? lc1_count : 16'h0000;
  assign rd_data_next = rd_en ? rd_sel : rd_data_reg;

  // ----------------------------------------------------------------
  // operand prefix
  // ----------------------------------------------------------------
  // held for one cycle only, then back to the default selection
  assign pfx_next = wr_pfx ? wr_data : `CFR_PFX_RST;
  assign pfx_idx_next = wr_pfx ? wr_idx[2:0] : `CFR_PFX_IDX_RST;

  // ----------------------------------------------------------------
  // loop counters
  // ----------------------------------------------------------------
  wire logic lc0_taken;
  wire logic lc1_taken;
  wire logic decrement_jump_nonzero_dec0;
  wire logic decrement_jump_nonzero_dec1;
  wire logic jump_taken;

  assign decrement_jump_nonzero_dec0 = decrement_jump_nonzero_en && !decrement_jump_nonzero_sel;
  assign decrement_jump_nonzero_dec1 = decrement_jump_nonzero_en && decrement_jump_nonzero_sel;
  assign jump_taken = lc0_taken || lc1_taken;

  cfr_loop_count #(
    .RST_VAL(`CFR_LC_RST)
  ) u_loop_zero (
    .clk(clk),
    .arst_n(arst_n),
    .load_en(wr_lc0),
    .load_data(wr_data),
    .dec_en(decrement_jump_nonzero_dec0),
    .count(lc0_count),
    .taken(lc0_taken)
  );

  cfr_loop_count #(
    .RST_VAL(`CFR_LC_RST)
  ) u_loop_one (
    .clk(clk),
    .arst_n(arst_n),
    .load_en(wr_lc1),
    .load_data(wr_data),
    .dec_en(decrement_jump_nonzero_dec1),
    .count(lc1_count),
    .taken(lc1_taken)
  );

  // ----------------------------------------------------------------
  // stack
  // ----------------------------------------------------------------
  wire logic stk_push;
  wire cfr_word_t stk_data;

  // interrupt call saves the return address
  assign stk_push = push_en || int_ack;
  assign stk_data = int_ack ? ip_reg : push_data;

  cfr_stack u_stack (
    .clk(clk),
    .arst_n(arst_n),
    .push_en(stk_push),
    .push_data(stk_data),
    .pop_en(pop_en),
    .pop_data(pop_data),
    .sp_wr_en(wr_sp),
    .sp_wr_data(wr_data[`CFR_SP_MSB:0]),
    .sp(stack_top_w)
  );

  // ----------------------------------------------------------------
  // fetch address and vector
  // ----------------------------------------------------------------
  // call beats a write, a write beats a branch, a branch beats a fetch
  assign ip_next = int_ack ? iv_reg :
                   wr_ip ? wr_data :
                   jump_taken ? decrement_jump_nonzero_target :
                   fetch_en ? ip_reg + 16'h0001 :
                   ip_reg;
  assign iv_next = wr_iv ? wr_data : iv_reg;

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pfx_reg <= `CFR_PFX_RST;
      pfx_idx_reg <= `CFR_PFX_IDX_RST;
      ip_reg <= `CFR_IP_RST;
      iv_reg <= `CFR_IV_RST;
      rd_data_reg <= 16'h0000;
      decrement_jump_nonzero_taken_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      pfx_reg <= pfx_next;
      pfx_idx_reg <= pfx_idx_next;
      ip_reg <= ip_next;
      iv_reg <= iv_next;
      rd_data_reg <= rd_data_next;
      decrement_jump_nonzero_taken_reg <= jump_taken;
      seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data = rd_data_reg;
  assign fetch_addr = ip_reg;
  assign pfx_data = pfx_reg[`CFR_PFX_DATA_MSB:0];
  assign pfx_src_hi = pfx_idx_reg[`CFR_PFX_SRC_BIT];
  assign pfx_dst_hi = pfx_idx_reg[`CFR_PFX_DST_MSB:`CFR_PFX_DST_LSB];
  assign stack_top = stack_top_w;
  assign decrement_jump_nonzero_taken = decrement_jump_nonzero_taken_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pfx_clear;
    @(posedge clk) disable iff (!arst_n)
      (wr_pfx ##1 !wr_pfx) |=>
      (pfx_reg == 16'h0000) && (pfx_dst_hi == 2'h0) && !pfx_src_hi;
  endproperty
  a_pfx_clear: assert property (p_pfx_clear)
    else $error("prefix did not clear after one cycle");

  property p_pfx_index;
    @(posedge clk) disable iff (!arst_n)
      wr_pfx |=> (pfx_src_hi == $past(wr_idx[0])) &&
                 (pfx_dst_hi == $past(wr_idx[2:1]));
  endproperty
  a_pfx_index: assert property (p_pfx_index)
    else $error("prefix index did not set high select bits");

  property p_pfx_data;
    @(posedge clk) disable iff (!arst_n)
      wr_pfx |=> (pfx_data == $past(wr_data[7:0])) &&
                 (pfx_reg == $past(wr_data));
  endproperty
  a_pfx_data: assert property (p_pfx_data)
    else $error("prefix data not passed on");

  property p_reset_vals;
    @(posedge clk) disable iff (!arst_n)
      !seen_reg |-> (fetch_addr == 16'h8000) && (stack_top == 4'hF) &&
                    (iv_reg == 16'h0000) && (lc0_count == 16'h0000) &&
                    (lc1_count == 16'h0000);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset value wrong");

  property p_ip_inc;
    @(posedge clk) disable iff (!arst_n)
      (fetch_en && !int_ack && !wr_ip && !jump_taken) |=>
      (fetch_addr == $past(fetch_addr) + 16'h0001);
  endproperty
  a_ip_inc: assert property (p_ip_inc)
    else $error("fetch address did not step by one");

  property p_ip_write;
    @(posedge clk) disable iff (!arst_n)
      (wr_ip && !int_ack) |=> (fetch_addr == $past(wr_data));
  endproperty
  a_ip_write: assert property (p_ip_write)
    else $error("write to fetch address did not jump");

  property p_ip_hold;
    @(posedge clk) disable iff (!arst_n)
      (!fetch_en && !int_ack && !wr_ip && !decrement_jump_nonzero_en) |=> $stable(fetch_addr);
  endproperty
  a_ip_hold: assert property (p_ip_hold)
    else $error("fetch address moved without cause");

  property p_sp_read;
    @(posedge clk) disable iff (!arst_n)
      (rd_en && rd_sp) |=> (rd_data[15:4] == 12'h000) &&
                          (rd_data[3:0] == $past(stack_top));
  endproperty
  a_sp_read: assert property (p_sp_read)
    else $error("stack pointer read shows reserved bits");

  property p_int_call;
    @(posedge clk) disable iff (!arst_n)
      (int_ack && !wr_sp) |=> (fetch_addr == $past(iv_reg)) &&
                  (stack_top == $past(stack_top) + 4'h1);
  endproperty
  a_int_call: assert property (p_int_call)
    else $error("interrupt acknowledge did not call the vector");

  property p_djnz0;
    @(posedge clk) disable iff (!arst_n)
      (decrement_jump_nonzero_dec0 && !int_ack && !wr_ip && (lc0_count != 16'h0001)) |=>
      (fetch_addr == $past(decrement_jump_nonzero_target)) && decrement_jump_nonzero_taken;
  endproperty
  a_djnz0: assert property (p_djnz0)
    else $error("counter zero branch not taken");

  property p_djnz1;
    @(posedge clk) disable iff (!arst_n)
      (decrement_jump_nonzero_dec1 && !int_ack && !wr_ip && !wr_lc1 &&
       (lc1_count == 16'h0001)) |=>
      !decrement_jump_nonzero_taken && (lc1_count == 16'h0000);
  endproperty
  a_djnz1: assert property (p_djnz1)
    else $error("counter one branch taken at zero");
endmodule

// [dv/cfr_flow_regs_tb.sv]
// self-checking testbench for the flow control register bank
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_flow_regs_tb;
  import cfr_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, arst_n, wr_en, rd_en, fetch_en, push_en, pop_en, int_ack;
  logic decrement_jump_nonzero_en, decrement_jump_nonzero_sel, pfx_src_hi, decrement_jump_nonzero_taken;
  cfr_sel_t wr_mod, wr_idx, rd_mod, rd_idx;
  cfr_word_t wr_data, rd_data, fetch_addr, push_data, pop_data;
  cfr_word_t decrement_jump_nonzero_target;
  cfr_pfx_data_t pfx_data;
  cfr_dst_hi_t pfx_dst_hi;
  cfr_sp_t stack_top;
  int fails, num_checks;
  // ----------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------
  cfr_flow_regs cfr_flow_regs_inst (
    .clk(clk), .arst_n(arst_n),
    .wr_en(wr_en), .wr_mod(wr_mod), .wr_idx(wr_idx), .wr_data(wr_data),
    .rd_en(rd_en), .rd_mod(rd_mod), .rd_idx(rd_idx), .rd_data(rd_data),
    .fetch_en(fetch_en), .fetch_addr(fetch_addr),
    .pfx_data(pfx_data), .pfx_src_hi(pfx_src_hi), .pfx_dst_hi(pfx_dst_hi),
    .push_en(push_en), .push_data(push_data), .pop_en(pop_en),
    .pop_data(pop_data), .stack_top(stack_top), .int_ack(int_ack),
    .decrement_jump_nonzero_en(decrement_jump_nonzero_en), .decrement_jump_nonzero_sel(decrement_jump_nonzero_sel), .decrement_jump_nonzero_target(decrement_jump_nonzero_target),
    .decrement_jump_nonzero_taken(decrement_jump_nonzero_taken)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input cfr_word_t got, input cfr_word_t exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input cfr_sel_t m, input cfr_sel_t i,
                    input cfr_word_t d);
    wr_en = 1'b1;
    wr_mod = m;
    wr_idx = i;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input cfr_sel_t m, input cfr_sel_t i,
                    output cfr_word_t d);
    rd_en = 1'b1;
    rd_mod = m;
    rd_idx = i;
    @(negedge clk);
    rd_en = 1'b0;
    d = rd_data;
    @(negedge clk);
  endtask
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
  endtask
  task automatic dj(input logic sel, input cfr_word_t tgt);
    decrement_jump_nonzero_en = 1'b1;
    decrement_jump_nonzero_sel = sel;
    decrement_jump_nonzero_target = tgt;
    @(negedge clk);
    decrement_jump_nonzero_en = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals;
    cfr_word_t d;
    chk(fetch_addr, 16'h8000, "fetch addr at reset");
    chk({12'h000, stack_top}, 16'h000F, "stack top at reset");
    chk({8'h00, pfx_data}, 16'h0000, "prefix data at reset");
    rd(`CFR_MOD_IP, `CFR_IDX_IP, d);
    chk(d, 16'h8000, "read fetch addr");
    rd(`CFR_MOD_SYS, `CFR_IDX_SP, d);
    chk(d, 16'h000F, "read stack ptr");
    rd(`CFR_MOD_SYS, `CFR_IDX_IV, d);
    chk(d, 16'h0000, "read vector");
    rd(`CFR_MOD_SYS, `CFR_IDX_LC0, d);
    chk(d, 16'h0000, "read loop zero");
    rd(`CFR_MOD_SYS, `CFR_IDX_LC1, d);
    chk(d, 16'h0000, "read loop one");
    rd(`CFR_MOD_PFX, 4'h4, d);
    chk(d, 16'h0000, "read prefix");
  endtask
  task automatic t_fetch;
    cfr_word_t d;
    for (int k = 1; k <= 3; k++) begin
      fetch_en = 1'b1;
      @(negedge clk);
      chk(fetch_addr, 16'h8000 + 16'(k), "fetch increment");
    end
    fetch_en = 1'b0;
    rd(`CFR_MOD_IP, `CFR_IDX_IP, d);
    chk(d, 16'h8003, "read next address");
    @(negedge clk);
    chk(fetch_addr, 16'h8003, "read leaves fetch addr");
  endtask
  task automatic t_jump;
    cfr_word_t d;
    wr(`CFR_MOD_IP, `CFR_IDX_IP, 16'h1234);
    chk(fetch_addr, 16'h1234, "jump by write");
    fetch_en = 1'b1;
    @(negedge clk);
    fetch_en = 1'b0;
    chk(fetch_addr, 16'h1235, "fetch after jump");
    rd(`CFR_MOD_IP, `CFR_IDX_IP, d);
    chk(d, 16'h1235, "read after jump");
  endtask
  task automatic t_prefix;
    cfr_word_t d;
    cfr_word_t q;
    for (int i = 0; i < 8; i++) begin
      d = 16'h7E00 | (16'h0011 * 16'(i));
      wr(`CFR_MOD_PFX, 4'(i), d);
      chk({8'h00, pfx_data}, {8'h00, d[7:0]}, "prefix low byte");
      chk({15'h0, pfx_src_hi}, 16'(i & 1), "source range");
      chk({14'h0, pfx_dst_hi}, 16'(i >> 1), "dest range");
      rd(`CFR_MOD_PFX, 4'(7 - i), q);
      chk(q, d, "prefix read any index");
      chk({8'h00, pfx_data}, 16'h0000, "prefix clears");
      chk({13'h0, pfx_src_hi, pfx_dst_hi}, 16'h0000, "default sel");
    end
  endtask
  task automatic t_stack;
    cfr_word_t d;
    push_en = 1'b1;
    push_data = 16'hA5A5;
    @(negedge clk);
    chk({12'h000, stack_top}, 16'h0000, "push wraps ptr");
    push_data = 16'h5A5A;
    @(negedge clk);
    push_en = 1'b0;
    chk({12'h000, stack_top}, 16'h0001, "second push");
    pop_en = 1'b1;
    @(negedge clk);
    chk(pop_data, 16'h5A5A, "pop last");
    chk({12'h000, stack_top}, 16'h0000, "pop decrements");
    @(negedge clk);
    pop_en = 1'b0;
    chk(pop_data, 16'hA5A5, "pop first");
    chk({12'h000, stack_top}, 16'h000F, "pop wraps ptr");
    wr(`CFR_MOD_SYS, `CFR_IDX_SP, 16'hFFF3);
    chk({12'h000, stack_top}, 16'h0003, "ptr write");
    rd(`CFR_MOD_SYS, `CFR_IDX_SP, d);
    chk(d, 16'h0003, "reserved ptr bits");
  endtask
  task automatic t_int;
    cfr_word_t d;
    wr(`CFR_MOD_SYS, `CFR_IDX_IV, 16'h4000);
    rd(`CFR_MOD_SYS, `CFR_IDX_IV, d);
    chk(d, 16'h4000, "vector readback");
    wr(`CFR_MOD_IP, `CFR_IDX_IP, 16'h2222);
    int_ack = 1'b1;
    @(negedge clk);
    int_ack = 1'b0;
    chk(fetch_addr, 16'h4000, "call to vector");
    chk({12'h000, stack_top}, 16'h0004, "return pushed");
    pop_en = 1'b1;
    @(negedge clk);
    pop_en = 1'b0;
    chk(pop_data, 16'h2222, "return address");
  endtask
  task automatic t_decrement_jump_nonzero;
    cfr_word_t d;
    cfr_word_t f;
    cfr_sel_t ix;
    for (int s = 0; s < 2; s++) begin
      ix = s ? `CFR_IDX_LC1 : `CFR_IDX_LC0;
      wr(`CFR_MOD_SYS, ix, 16'h0003);
      dj(1'(s), 16'h1000 + 16'(s));
      chk(fetch_addr, 16'h1000 + 16'(s), "branch taken");
      chk({15'h0, decrement_jump_nonzero_taken}, 16'h0001, "taken flag");
      rd(`CFR_MOD_SYS, ix, d);
      chk(d, 16'h0002, "count decremented");
      wr(`CFR_MOD_SYS, ix, 16'h0001);
      f = fetch_addr;
      dj(1'(s), 16'h3000);
      chk(fetch_addr, f, "no branch at zero");
      chk({15'h0, decrement_jump_nonzero_taken}, 16'h0000, "not taken flag");
      rd(`CFR_MOD_SYS, ix, d);
      chk(d, 16'h0000, "count reached zero");
      dj(1'(s), 16'h3000);
      chk(fetch_addr, 16'h3000, "branch on wrap");
      rd(`CFR_MOD_SYS, ix, d);
      chk(d, 16'hFFFF, "count wraps");
    end
  endtask
  task automatic t_unmapped;
    cfr_word_t d;
    wr(`CFR_MOD_SYS, 4'h5, 16'hBEEF);
    rd(`CFR_MOD_SYS, 4'h5, d);
    chk(d, 16'h0000, "unmapped system");
    rd(4'hA, 4'h0, d);
    chk(d, 16'h0000, "unmapped module");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    num_checks = 0;
    {wr_en, rd_en, fetch_en, push_en, pop_en, int_ack, decrement_jump_nonzero_en} = 7'h00;
    decrement_jump_nonzero_sel = 1'b0;
    {wr_mod, wr_idx, rd_mod, rd_idx} = 16'h0000;
    {wr_data, push_data, decrement_jump_nonzero_target} = 48'h0;
    arst_n = 1'b0;
    @(negedge clk);
    do_reset;
    t_reset_vals;
    t_fetch;
    t_jump;
    t_prefix;
    t_stack;
    t_int;
    t_decrement_jump_nonzero;
    t_unmapped;
    do_reset;
    t_reset_vals;
    conclude;
  end
  initial begin
    #100000;
    fails++;
    conclude;
  end
endmodule
